/* File: hdl/adc_seq_pkg.sv */
package adc_seq_pkg;

	// ======================================================================
	// Register map (byte addresses on the bus)
	localparam logic [7:0] CSR_OFS = 8'h00;
	localparam logic [7:0] CTRL_OFS = 8'h04;
	localparam logic [7:0] RES_BASE = 8'h08;
	localparam logic [7:0] RES_LAST = 8'h24;

	// ======================================================================
	// Field codes and fixed values
	localparam logic [1:0] BUF_OFF = 2'h0;
	localparam logic [1:0] BUF_AB = 2'h1;
	localparam logic [1:0] BUF_PAIR = 2'h2;
	localparam logic [1:0] BUF_CHAIN = 2'h3;
	localparam logic [2:0] REG_A = 3'h0;
	localparam logic [2:0] REG_B = 3'h1;
	localparam logic [2:0] REG_D = 3'h3;
	localparam logic [2:0] IN_2 = 3'h2;
	localparam logic [2:0] IN_4 = 3'h4;
	localparam logic [2:0] HSIZE_BYTE = 3'h0;
	localparam logic [2:0] BUF_COUNT_MAX = 3'h4;
	localparam int RES_W = 10;

	// ======================================================================
	// Register layouts
	typedef struct packed {
		logic done_flag;
		logic done_irq_enable;
		logic conversion_go;
		logic timer_trigger_select;
		logic scan_mode;
		logic pair_sampling_enable;
		logic [1:0] buffer_select;
	} csr_t;

	typedef struct packed {
		logic dma_clear_enable;
		logic group_mode_select;
		logic [2:0] channel_select;
	} ctrl_t;

	localparam csr_t CSR_RESET = '0;
	localparam ctrl_t CTRL_RESET = '0;

	// ======================================================================
	// Internal carriers
	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_PAUSE} seq_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic byte_rd;
		logic [7:0] addr;
	} bus_req_t;

	typedef struct packed {
		logic valid;
		logic [1:0] kind;
		logic [2:0] dest;
		logic [RES_W-1:0] data;
	} store_t;

	typedef struct packed {
		logic [3:0] len;
		logic [1:0] prefix;
		logic [2:0] first;
		logic buf_only;
		logic [2:0] target;
		logic [2:0] last_reg;
	} plan_t;

endpackage : adc_seq_pkg

/* File: hdl/adc_sequencer.sv */
// Summary of operation
// RULE1 - Scan keeps go set until software clears.
// RULE2 - Group scan sets flag after first pass.
// RULE3 - Flag with irq enable pauses scan.
// RULE4 - Flag clears by zero write after read.
// RULE5 - Buffered result shifts chain same step.
// RULE6 - Buffer select picks chain topology.
// RULE7 - Pair plus buffer needs group, 10, top zero.
// RULE8 - Buffer-only group: channel bits set count.
// RULE9 - Buffer-only flag after one to four conversions.
// RULE10 - Buffered single stops; buffered scan continues.
// RULE11 - Select single buffered: standby each pass.
// RULE12 - Combined mode appends inputs two to seven.
// RULE13 - Chain 11 code 110 fills A, E-G.
// RULE14 - DMA read of last register clears flag.
// RULE15 - Writing buffer select 00 idle resets count.
// RULE16 - Change buffering via 00 while idle.
// RULE17 - Pair sampling only in group mode.
// RULE18 - Upper channel bits choose pair sequence.
// RULE19 - Dedicated bit enables pair sampling, reset zero.
// RULE20 - Halfword read full, byte read top bits.
// RULE21 - Unavailable combinations left undefined.
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
module adc_sequencer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic timer_trig,
	input wire logic conv_done,
	input wire logic [9:0] conv_data,
	output logic conv_req,
	output logic [2:0] conv_channel,
	output logic conv_pair,
	output logic conversion_end_irq
);
	typedef struct packed {
		adc_seq_pkg::csr_t csr;
		adc_seq_pkg::ctrl_t ctrl;
		logic armed;
		adc_seq_pkg::seq_state_t state;
		logic [3:0] step;
		logic [2:0] buf_count;
		logic conv_req;
		logic [2:0] conv_channel;
		logic conv_pair;
		logic irq;
		logic [31:0] hrdata;
		adc_seq_pkg::store_t store;
	} seq_reg_t;

	seq_reg_t st_reg;
	seq_reg_t st_next;
	adc_seq_pkg::bus_req_t rd;
	adc_seq_pkg::bus_req_t wr;
	adc_seq_pkg::plan_t plan;
	adc_seq_pkg::csr_t wcsr;
	logic [7:0] res_ofs;
	logic [2:0] res_idx;
	logic [31:0] bank_rdata;
	logic [2:0] chan;
	logic in_prefix;
	logic last_step;
	logic pair_now;
	logic conv_hit;
	logic pass_end;
	logic flag_ev;
	logic wr_csr;
	logic wr_ctrl;
	logic rd_csr;
	logic rd_res;
	logic dma_hit;
	logic flag_clear;
	logic halted;

	// ======================================================================
	// Conversion plan: buffered prefix (input 0, or 0 and 1) followed by an
	// appended run of inputs that each store to the register of their number.
	function automatic adc_seq_pkg::plan_t make_plan(adc_seq_pkg::csr_t c,
		adc_seq_pkg::ctrl_t k);
		adc_seq_pkg::plan_t p;
		logic combined;
		logic [2:0] last;
		p = '0;
		last = k.channel_select;
		// RULE12 combined appended inputs.
		combined = k.group_mode_select && (k.channel_select[2] ||
			(c.buffer_select == adc_seq_pkg::BUF_AB && k.channel_select[1]));
		// RULE8 buffer-only selection.
		p.buf_only = (c.buffer_select != adc_seq_pkg::BUF_OFF) && !combined;
		case (c.buffer_select)
			adc_seq_pkg::BUF_OFF: p.prefix = 2'h0;
			adc_seq_pkg::BUF_PAIR: p.prefix = 2'h2;
			default: p.prefix = 2'h1;
		endcase
		if (c.buffer_select == adc_seq_pkg::BUF_OFF) begin
			p.first = k.group_mode_select ? 3'h0 : k.channel_select;
			// RULE18 pair sequence length.
			if (k.group_mode_select && c.pair_sampling_enable) begin
				last = {k.channel_select[2:1], 1'b1};
			end
		end else if (c.buffer_select == adc_seq_pkg::BUF_AB) begin
			p.first = adc_seq_pkg::IN_2;
			last = k.channel_select[2] ? adc_seq_pkg::IN_4 + {1'b0, k.channel_select[1:0]}
				: adc_seq_pkg::IN_2 + {2'b00, k.channel_select[0]};
		end else begin
			// RULE13 appended from input four.
			p.first = adc_seq_pkg::IN_4;
			last = adc_seq_pkg::IN_4 + {1'b0, k.channel_select[1:0]};
		end
		if (p.buf_only) begin
			p.len = {2'b00, p.prefix};
		end else begin
			p.len = {2'b00, p.prefix} + {1'b0, last} - {1'b0, p.first} + 4'h1;
		end
		// RULE9 buffer-only pass counts.
		if (c.buffer_select == adc_seq_pkg::BUF_PAIR) begin
			p.target = k.channel_select[1] ? 3'h2 : 3'h1;
			p.last_reg = k.channel_select[1] ? adc_seq_pkg::REG_D : adc_seq_pkg::REG_B;
		end else begin
			p.target = {1'b0, k.channel_select[1:0]} + 3'h1;
			p.last_reg = {1'b0, k.channel_select[1:0]};
		end
		if (!p.buf_only) begin
			p.last_reg = last;
		end
		return p;
	endfunction : make_plan

	// ======================================================================
	// Bus front and result storage
	ahb_reg_port u_port (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.rd(rd),
		.wr(wr),
		.hreadyout(hreadyout),
		.hresp(hresp)
	);

	result_bank u_bank (
		.hclk(hclk),
		.hresetn(hresetn),
		.store(st_reg.store),
		.rd_idx(res_idx),
		.rd_byte(rd.byte_rd),
		.rd_data(bank_rdata)
	);

	// ======================================================================
	// Step decode
	assign plan = make_plan(st_reg.csr, st_reg.ctrl);
	assign in_prefix = st_reg.step < {2'b00, plan.prefix};
	assign chan = in_prefix ? st_reg.step[2:0]
		: plan.first + (st_reg.step[2:0] - {1'b0, plan.prefix});
	assign last_step = (st_reg.step + 4'h1) == plan.len;
	// RULE17 pairs only in group mode.
	assign pair_now = st_reg.csr.pair_sampling_enable && st_reg.ctrl.group_mode_select &&
		!chan[0] && (st_reg.csr.buffer_select == adc_seq_pkg::BUF_OFF ||
		st_reg.csr.buffer_select == adc_seq_pkg::BUF_PAIR);
	assign conv_hit = (st_reg.state == adc_seq_pkg::ST_WAIT) && conv_done;
	assign pass_end = conv_hit && last_step;
	// RULE2 flag at pass end.
	assign flag_ev = pass_end &&
		(!plan.buf_only || (st_reg.buf_count + 3'h1) == plan.target);
	assign halted = (st_reg.state == adc_seq_pkg::ST_IDLE) ||
		(st_reg.state == adc_seq_pkg::ST_PAUSE);

	// ======================================================================
	// Register access decode
	assign wcsr = adc_seq_pkg::csr_t'(hwdata[7:0]);
	assign wr_csr = wr.valid && wr.addr == adc_seq_pkg::CSR_OFS;
	assign wr_ctrl = wr.valid && wr.addr == adc_seq_pkg::CTRL_OFS;
	assign rd_csr = rd.valid && rd.addr == adc_seq_pkg::CSR_OFS;
	assign res_ofs = rd.addr - adc_seq_pkg::RES_BASE;
	assign res_idx = res_ofs[4:2];
	assign rd_res = rd.valid && rd.addr >= adc_seq_pkg::RES_BASE &&
		rd.addr <= adc_seq_pkg::RES_LAST && rd.addr[1:0] == 2'b00;
	// RULE14 DMA read clears flag.
	assign dma_hit = st_reg.ctrl.dma_clear_enable && rd_res && res_idx == plan.last_reg;
	// RULE4 zero write after read.
	assign flag_clear = (wr_csr && !wcsr.done_flag && st_reg.armed) || dma_hit;

	// ======================================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.conv_req = 1'b0;
		st_next.store.valid = 1'b0;
		if (wr_csr) begin
			st_next.csr.done_irq_enable = wcsr.done_irq_enable;
			st_next.csr.conversion_go = wcsr.conversion_go;
			st_next.csr.timer_trigger_select = wcsr.timer_trigger_select;
			st_next.csr.scan_mode = wcsr.scan_mode;
			// RULE19 pair sampling bit.
			st_next.csr.pair_sampling_enable = wcsr.pair_sampling_enable;
			st_next.csr.buffer_select = wcsr.buffer_select;
			// RULE15 count reset on 00.
			if (wcsr.buffer_select == adc_seq_pkg::BUF_OFF && halted) begin
				st_next.buf_count = 3'h0;
			end
		end
		if (wr_ctrl) begin
			st_next.ctrl = adc_seq_pkg::ctrl_t'(hwdata[4:0]);
		end
		// RULE11 timer restart from standby.
		if (st_reg.csr.timer_trigger_select && timer_trig &&
			st_reg.state == adc_seq_pkg::ST_IDLE) begin
			st_next.csr.conversion_go = 1'b1;
		end
		if (rd_csr && st_reg.csr.done_flag) begin
			st_next.armed = 1'b1;
		end
		if (flag_clear) begin
			st_next.csr.done_flag = 1'b0;
			st_next.armed = 1'b0;
		end
		case (st_reg.state)
			adc_seq_pkg::ST_IDLE: begin
				if (st_reg.csr.conversion_go) begin
					st_next.step = 4'h0;
					st_next.state = adc_seq_pkg::ST_ISSUE;
				end
			end
			adc_seq_pkg::ST_ISSUE: begin
				st_next.conv_req = 1'b1;
				st_next.conv_channel = chan;
				st_next.conv_pair = pair_now;
				st_next.state = adc_seq_pkg::ST_WAIT;
			end
			adc_seq_pkg::ST_WAIT: begin
				if (conv_done) begin
					st_next.store.valid = 1'b1;
					st_next.store.kind = in_prefix ? st_reg.csr.buffer_select
						: adc_seq_pkg::BUF_OFF;
					st_next.store.dest = chan;
					st_next.store.data = conv_data;
					st_next.state = adc_seq_pkg::ST_ISSUE;
					st_next.step = st_reg.step + 4'h1;
					if (last_step) begin
						st_next.step = 4'h0;
						if (plan.buf_only) begin
							st_next.buf_count = flag_ev ? 3'h0 : st_reg.buf_count + 3'h1;
						end
						// RULE10 single stops after flag, or after each pass outside group mode.
						if (!st_reg.csr.scan_mode &&
							(flag_ev || !st_reg.ctrl.group_mode_select)) begin
							st_next.csr.conversion_go = 1'b0;
							st_next.state = adc_seq_pkg::ST_IDLE;
						// RULE3 pause on flag.
						end else if (st_reg.csr.scan_mode && st_reg.csr.done_irq_enable &&
							(flag_ev || st_reg.csr.done_flag)) begin
							st_next.state = adc_seq_pkg::ST_PAUSE;
						end
					end
				end
			end
			adc_seq_pkg::ST_PAUSE: begin
				// RULE3 resume when flag clears.
				if (!st_reg.csr.done_flag) begin
					st_next.state = adc_seq_pkg::ST_ISSUE;
				end
			end
			default: begin
				st_next.state = adc_seq_pkg::ST_IDLE;
			end
		endcase
		// RULE1 scan go only cleared by software.
		if (!st_reg.csr.conversion_go) begin
			st_next.state = adc_seq_pkg::ST_IDLE;
		end
		if (flag_ev) begin
			st_next.csr.done_flag = 1'b1;
		end
		st_next.irq = st_next.csr.done_flag && st_next.csr.done_irq_enable;
		// RULE20 result read view.
		st_next.hrdata = 32'h0000_0000;
		if (rd_csr) begin
			st_next.hrdata = {24'h00_0000, st_reg.csr};
		end else if (rd.valid && rd.addr == adc_seq_pkg::CTRL_OFS) begin
			st_next.hrdata = {27'h000_0000, st_reg.ctrl};
		end else if (rd_res) begin
			st_next.hrdata = bank_rdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '{csr: adc_seq_pkg::CSR_RESET, ctrl: adc_seq_pkg::CTRL_RESET,
				state: adc_seq_pkg::ST_IDLE, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign hrdata = st_reg.hrdata;
	assign conv_req = st_reg.conv_req;
	assign conv_channel = st_reg.conv_channel;
	assign conv_pair = st_reg.conv_pair;
	assign conversion_end_irq = st_reg.irq;

	// ======================================================================
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_go_held: assert property ( // RULE1
		st_reg.csr.conversion_go && st_reg.csr.scan_mode && !wr_csr |=>
		st_reg.csr.conversion_go)
		else $error("scan go bit dropped without software");
	chk_flag_pass: assert property ( // RULE2
		pass_end && !plan.buf_only |=> st_reg.csr.done_flag)
		else $error("flag not set at pass end");
	chk_pause_quiet: assert property ( // RULE3
		st_reg.state == adc_seq_pkg::ST_PAUSE && st_reg.csr.done_flag |=> !conv_req [*2])
		else $error("conversion issued while paused");
	chk_irq_follow: assert property ( // RULE3
		$rose(st_reg.csr.done_flag) && st_reg.csr.done_irq_enable |-> conversion_end_irq)
		else $error("irq did not follow flag");
	chk_flag_clear: assert property ( // RULE4
		$fell(st_reg.csr.done_flag) |-> $past(st_reg.armed) || $past(dma_hit))
		else $error("flag cleared without read or dma");
	chk_count_bound: assert property ( // RULE9
		st_reg.buf_count < adc_seq_pkg::BUF_COUNT_MAX)
		else $error("buffer count out of range");
	chk_single_stop: assert property ( // RULE10
		flag_ev && !st_reg.csr.scan_mode |=> !st_reg.csr.conversion_go ##1
		st_reg.state == adc_seq_pkg::ST_IDLE)
		else $error("single mode did not stop");
	chk_count_reset: assert property ( // RULE15
		wr_csr && wcsr.buffer_select == adc_seq_pkg::BUF_OFF && halted |=>
		st_reg.buf_count == 3'h0)
		else $error("buffer count not reset");
	chk_pair_even: assert property ( // RULE18
		conv_req && conv_pair |-> !conv_channel[0] ##1 !conv_req)
		else $error("pair sample on odd input");

	cov_pause: cover property (st_reg.state == adc_seq_pkg::ST_PAUSE ##1
		st_reg.state == adc_seq_pkg::ST_ISSUE);
	cov_dma_clear: cover property (dma_hit && st_reg.csr.done_flag);
	cov_buf_flag: cover property (flag_ev && plan.buf_only);
	cov_pair: cover property (conv_req && conv_pair);

endmodule : adc_sequencer

/* File: hdl/ahb_reg_port.sv */
`timescale 1ns/100ps
module ahb_reg_port (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	output adc_seq_pkg::bus_req_t rd,
	output adc_seq_pkg::bus_req_t wr,
	output logic hreadyout,
	output logic hresp
);
	typedef struct packed {
		adc_seq_pkg::bus_req_t wr;
		logic ready;
	} port_state_t;

	port_state_t st;
	port_state_t nx;
	adc_seq_pkg::bus_req_t req;

	// ======================================================================
	// Address phase decode; reads answer in the data phase from a flop.
	always_comb begin
		req.valid = hsel && htrans[1] && hready;
		req.write = hwrite;
		req.byte_rd = (hsize == adc_seq_pkg::HSIZE_BYTE);
		req.addr = haddr[7:0];
		nx = st;
		nx.ready = 1'b1;
		nx.wr = req;
		nx.wr.valid = req.valid && hwrite;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign rd = '{valid: req.valid && !hwrite, write: 1'b0, byte_rd: req.byte_rd,
		addr: req.addr};
	assign wr = st.wr;
	assign hreadyout = st.ready;
	assign hresp = 1'b0;

endmodule : ahb_reg_port

/* File: hdl/result_bank.sv */
`timescale 1ns/100ps
module result_bank (
	input wire logic hclk,
	input wire logic hresetn,
	input adc_seq_pkg::store_t store,
	input wire logic [2:0] rd_idx,
	input wire logic rd_byte,
	output logic [31:0] rd_data
);
	typedef struct packed {
		logic [7:0][adc_seq_pkg::RES_W-1:0] res;
	} bank_state_t;

	bank_state_t st;
	bank_state_t nx;

	// Word or halfword reads give the left-justified result, byte reads its top eight bits.
	function automatic logic [31:0] read_view(logic [adc_seq_pkg::RES_W-1:0] r, logic b);
		if (b) begin
			return {4{r[9:2]}};
		end
		return {16'h0000, r, 6'h00};
	endfunction : read_view

	// ======================================================================
	// A buffered result lands at the head; older contents move down in the same step.
	always_comb begin
		nx = st;
		if (store.valid) begin
			case (store.kind)
				// RULE6 two-stage chain.
				adc_seq_pkg::BUF_AB: begin
					nx.res[1] = st.res[0];
					nx.res[0] = store.data;
				end
				adc_seq_pkg::BUF_PAIR: begin
					nx.res[store.dest + 3'h2] = st.res[store.dest];
					nx.res[store.dest] = store.data;
				end
				// RULE5 four-stage shift.
				adc_seq_pkg::BUF_CHAIN: begin
					nx.res[3:1] = st.res[2:0];
					nx.res[0] = store.data;
				end
				default: begin
					nx.res[store.dest] = store.data;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign rd_data = read_view(st.res[rd_idx], rd_byte);

	// ======================================================================
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_ab_shift: assert property ( // RULE6
		store.valid && store.kind == adc_seq_pkg::BUF_AB |=>
		st.res[1] == $past(st.res[0]) && st.res[0] == $past(store.data))
		else $error("two-stage chain did not shift");
	chk_chain_shift: assert property ( // RULE5
		store.valid && store.kind == adc_seq_pkg::BUF_CHAIN |=>
		st.res[3] == $past(st.res[2]) && st.res[1] == $past(st.res[0]))
		else $error("four-stage chain did not shift");

endmodule : result_bank

/* File: test/analog_core_model.sv */
`timescale 1ns/100ps
// ======================================================================
// Analog core stand-in: one conversion at a time, answered after a variable delay.
module analog_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic conv_req,
	input wire logic [2:0] conv_channel,
	input wire logic [3:0] delay,
	output logic conv_done,
	output logic [9:0] conv_data
);
	logic busy;
	logic [3:0] left;
	logic [2:0] ch;
	logic [6:0] cnt[8];

	// A result is the channel and its own conversion count; between results the data toggles.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy <= 1'b0;
			left <= 4'h0;
			ch <= 3'h0;
			conv_done <= 1'b0;
			conv_data <= 10'h155;
			for (int i = 0; i < 8; i++) begin
				cnt[i] <= 7'h00;
			end
		end else begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
			if (busy && left == 4'h0) begin
				busy <= 1'b0;
				conv_done <= 1'b1;
				conv_data <= {ch, cnt[ch]};
				cnt[ch] <= cnt[ch] + 7'h01;
			end else if (busy) begin
				left <= left - 4'h1;
			end else if (conv_req) begin
				busy <= 1'b1;
				left <= delay;
				ch <= conv_channel;
			end
		end
	end
endmodule : analog_core_model

/* File: test/tb_adc_sequencer_buffer_pairs.sv */
`timescale 1ns/100ps
module tb_adc_sequencer_buffer_pairs;
	logic hclk, hresetn, hsel, hwrite, timer_trig, conv_done, conv_req, conv_pair;
	logic hreadyout, hresp, conversion_end_irq, irq_q, rdy_q;
	logic [31:0] haddr, hwdata, hrdata, rd_q, r;
	logic [1:0] htrans;
	logic [2:0] hsize, conv_channel;
	logic [9:0] conv_data;
	logic [3:0] lat;
	logic [3:0] reqs[$];
	logic [10:0] e;
	logic [4:0] tbl[8] = '{5'h08, 5'h09, 5'h10, 5'h12, 5'h18, 5'h19, 5'h1A, 5'h1B};
	logic [9:0] exp13[7] = '{10'h004, 10'h003, 10'h002, 10'h001, 10'h200, 10'h280, 10'h300};
	int n_fail = 0, checked = 0, n_req = 0, seed = 14199, k;

	adc_sequencer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_trig(timer_trig),
		.conv_done(conv_done), .conv_data(conv_data), .conv_req(conv_req),
		.conv_channel(conv_channel), .conv_pair(conv_pair),
		.conversion_end_irq(conversion_end_irq));
	analog_core_model core_u (.hclk(hclk), .hresetn(hresetn), .conv_req(conv_req),
		.conv_channel(conv_channel), .delay(lat), .conv_done(conv_done), .conv_data(conv_data));

	// ======================================================================
	// Clock, sampling and random core latency
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(negedge hclk) begin
		rd_q = hrdata;
		rdy_q = hreadyout;
		irq_q = conversion_end_irq;
		if (conv_req === 1'b1) begin
			n_req++;
			reqs.push_back({conv_pair, conv_channel});
		end
	end
	always @(posedge hclk) lat <= 4'($random(seed) & 7);

	// ======================================================================
	// Tasks
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check
	task automatic wait_rdy();
		int t;
		t = 0;
		@(posedge hclk);
		while (rdy_q !== 1'b1) begin
			if (++t > 50) begin
				n_fail++;
				conclude();
			end
			@(posedge hclk);
		end
	endtask : wait_rdy
	task automatic bus(input logic w, input logic [7:0] a, input logic [2:0] sz,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= sz;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = rd_q;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, 3'h2, d, x);
	endtask : wr
	task automatic do_reset();
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		reqs.delete();
		n_req = 0;
	endtask : do_reset
	task automatic poll(input logic [7:0] mask, input logic [7:0] val);
		for (int t = 0; t < 80; t++) begin
			bus(1'b0, adc_seq_pkg::CSR_OFS, 3'h2, 32'h0, r);
			if ((r[7:0] & mask) === val) return;
		end
		n_fail++;
		conclude();
	endtask : poll
	task automatic wait_irq(input logic v);
		for (int t = 0; t < 300; t++) begin
			@(posedge hclk);
			if (irq_q === v) return;
		end
		n_fail++;
		conclude();
	endtask : wait_irq
	task automatic rd_res(input int idx, input logic [9:0] v);
		bus(1'b0, 8'(adc_seq_pkg::RES_BASE + 4 * idx), 3'h2, 32'h0, r);
		check("result word", {16'h0, v, 6'h00}, r);
	endtask : rd_res
	function automatic logic [31:0] csrv(input logic ie, go, trig, scan, pair, input logic [1:0] b);
		adc_seq_pkg::csr_t c;
		c = '{1'b0, ie, go, trig, scan, pair, b};
		return {24'h0, c};
	endfunction : csrv
	function automatic logic [10:0] exp_buf(input logic [1:0] b, input logic [2:0] code, int idx);
		int n, s, c;
		n = (b == adc_seq_pkg::BUF_PAIR) ? code[1] + 1 : code + 1;
		s = (b == adc_seq_pkg::BUF_PAIR) ? idx / 2 : idx;
		c = (b == adc_seq_pkg::BUF_PAIR) ? idx % 2 : 0;
		return {s < n, 3'(c), 7'(n - 1 - s)};
	endfunction : exp_buf

	// ======================================================================
	// Main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		timer_trig = 1'b0;
		lat = 4'h0;
		do_reset();
		bus(1'b0, adc_seq_pkg::CSR_OFS, 3'h2, 32'h0, r);
		check("csr reset", 32'h0, r);
		check("bus response", 32'h0, {31'h0, hresp});
		wr(8'h28, $random(seed));
		bus(1'b0, 8'h28, 3'h2, 32'h0, r);
		check("unmapped read", 32'h0, r);
		// only available buffer and channel codes are used.
		foreach (tbl[i]) begin
			do_reset();
			wr(adc_seq_pkg::CTRL_OFS, {27'h0, 2'b01, tbl[i][2:0]});
			wr(adc_seq_pkg::CSR_OFS, csrv(0, 1, 0, 0, 0, tbl[i][4:3]));
			poll(8'hA0, 8'h80);
			for (int j = 0; j < 4; j++) begin
				e = exp_buf(tbl[i][4:3], tbl[i][2:0], j);
				if (e[10]) rd_res(j, e[9:0]);
			end
			bus(1'b0, adc_seq_pkg::RES_BASE, adc_seq_pkg::HSIZE_BYTE, 32'h0, r);
			e = exp_buf(tbl[i][4:3], tbl[i][2:0], 0);
			check("result byte", {4{e[9:2]}}, r);
		end
		wr(adc_seq_pkg::CTRL_OFS, {27'h0, 2'b01, 3'h6});
		wr(adc_seq_pkg::CSR_OFS, csrv(0, 1, 0, 0, 0, 2'h3));
		poll(8'hA0, 8'h80);
		foreach (exp13[j]) rd_res(j, exp13[j]);
		do_reset();
		wr(adc_seq_pkg::CTRL_OFS, {27'h0, 2'b00, 3'h1});
		wr(adc_seq_pkg::CSR_OFS, csrv(0, 1, 0, 0, 0, 2'h3));
		poll(8'hA0, 8'h00);
		// buffering is reset through code 00 while idle.
		wr(adc_seq_pkg::CSR_OFS, csrv(0, 0, 0, 0, 0, 2'h0));
		wr(adc_seq_pkg::CSR_OFS, csrv(0, 1, 0, 0, 0, 2'h3));
		poll(8'hA0, 8'h00);
		wr(adc_seq_pkg::CSR_OFS, csrv(0, 0, 1, 0, 0, 2'h3));
		timer_trig <= 1'b1;
		@(posedge hclk);
		timer_trig <= 1'b0;
		poll(8'h80, 8'h80);
		rd_res(0, 10'h002);
		rd_res(1, 10'h001);
		do_reset();
		wr(adc_seq_pkg::CTRL_OFS, {27'h0, 2'b01, 3'h0});
		wr(adc_seq_pkg::CSR_OFS, csrv(1, 1, 0, 1, 0, 2'h3));
		wait_irq(1'b1);
		bus(1'b0, adc_seq_pkg::CSR_OFS, 3'h2, 32'h0, r);
		check("scan go and flag", 32'hA0, r & 32'hA0);
		k = n_req;
		repeat (20) @(posedge hclk);
		check("paused requests", k, n_req);
		wr(adc_seq_pkg::CSR_OFS, csrv(1, 1, 0, 1, 0, 2'h3));
		wait_irq(1'b0);
		wait_irq(1'b1);
		check("resumed", 1, n_req > k);
		wr(adc_seq_pkg::CSR_OFS, csrv(1, 1, 0, 1, 0, 2'h3));
		bus(1'b0, adc_seq_pkg::CSR_OFS, 3'h2, 32'h0, r);
		check("flag without read", 32'h80, r & 32'h80);
		wr(adc_seq_pkg::CSR_OFS, csrv(1, 1, 0, 1, 0, 2'h3));
		wait_irq(1'b0);
		wr(adc_seq_pkg::CSR_OFS, 32'h0);
		do_reset();
		wr(adc_seq_pkg::CTRL_OFS, {27'h0, 2'b11, 3'h1});
		wr(adc_seq_pkg::CSR_OFS, csrv(0, 1, 0, 0, 0, 2'h3));
		poll(8'h80, 8'h80);
		rd_res(1, 10'h000);
		bus(1'b0, adc_seq_pkg::CSR_OFS, 3'h2, 32'h0, r);
		check("flag after last read", 32'h0, r & 32'h80);
		for (int h = 0; h < 6; h++) begin
			do_reset();
			wr(adc_seq_pkg::CTRL_OFS, {27'h0, 1'b0, h != 4, h < 4 ? 2'(h) : 2'h0, 1'b0});
			wr(adc_seq_pkg::CSR_OFS, csrv(0, 1, 0, 0, 1, {h == 5, 1'b0}));
			poll(8'hA0, 8'h80);
			if (h != 4) check("pair count", h == 5 ? 2 : 2 * (h + 1), reqs.size());
			foreach (reqs[i]) begin
				if (h != 4) check("pair order", {i % 2 == 0, 3'(i)}, reqs[i]);
				else check("no pair in select", 0, reqs[i][3]);
			end
		end
		conclude();
	end
	initial begin
		repeat (60000) @(posedge hclk);
		n_fail++;
		conclude();
	end
endmodule : tb_adc_sequencer_buffer_pairs
